// [dv/test_usb_packet_ready_irq.sv]
`timescale 1ns/1ns
module test_usb_packet_ready_irq;
  import usb_pkt_irq_pkg::*;
  logic clk = 1'h0;
  logic resetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0;
  logic [2:0] s_axi_arprot = 3'h0;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irqOutN, ctrlReadDataStage;
  logic [1:0] s_axi_bresp, s_axi_rresp, rxPacketGood;
  logic [31:0] s_axi_rdata, rdv;
  logic [3:0] txFifoFree, txHostAck, txArmed, txShort;
  logic [6:0] txFillCount0, txFillCount1, txFillCount2, txFillCount3, rxByteCount;
  logic [6:0] txSendLen0, txSendLen1, txSendLen2, txSendLen3;
  logic [7:0] endpointStatus;
  int err_count = 0;
  int checks_done = 0;
  usb_packet_ready_irq dut (.*);
  usb_host_model host (.*);
  always #2 clk = ~clk;
  task automatic stop_test();
    $display("mismatches %0d, checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic nw(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Ready and answer are sampled at the falling edge, then acted on at the rising edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic ta, tw, tq, tr;
    logic [1:0] rsp;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    repeat (40) begin
      @(negedge clk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      tq = s_axi_arready;
      tr = w ? s_axi_bvalid : s_axi_rvalid;
      rsp = w ? s_axi_bresp : s_axi_rresp;
      rdv = s_axi_rdata;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      if (tq) s_axi_arvalid <= 1'h0;
      if (tr) begin
        s_axi_bready <= 1'h0;
        s_axi_rready <= 1'h0;
        chk(32'(rsp), 32'(er));
        return;
      end
    end
    err_count++;
    stop_test();
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    acc(1'h0, a, 8'h00, RESP_OKAY);
    chk(rdv, {24'h0, e});
  endtask
  task automatic arm(input int e, input logic [7:0] b, input logic [6:0] n, input logic [6:0] mx);
    for (int k = 0; k < 2; k++) begin
      host.load(e, k ? mx : n);
      acc(1'h1, OFF_PACKET_READY, b, RESP_OKAY);
      nw(1);
      chk(32'(irqOutN), 32'h1);
      chk(32'(txArmed[e]), 32'h1);
      chk(32'(txShort[e]), 32'(k == 0 && n < mx));
      chk(32'(endpointStatus[4 + e]), 32'(k == 0 && n < mx));
      chk(32'({txSendLen3, txSendLen2, txSendLen1, txSendLen0} >> (7 * e)) & 32'h7F, 32'(k ? mx : n));
      rd(OFF_EP0_TX_LEN + 8'(4 * e), {1'h0, k ? mx : n});
      if (k == 0) begin
        nw(6);
        chk(32'(txArmed[e] & endpointStatus[e]), 32'h1);
        host.ack(e);
        nw(4);
        chk(32'(txArmed[e]), 32'h0);
        chk(32'(irqOutN), 32'h0);
      end
    end
  endtask
  task automatic s_reset();
    nw(1);
    chk(32'(irqOutN), 32'h1);
    rd(OFF_PACKET_READY, 8'h90);
    rd(OFF_INT_ENABLE, RST_INT_ENABLE);
    rd(OFF_EP1_CONTROL, 8'h00);
    acc(1'h1, 8'h30, 8'hFF, RESP_SLVERR);
    acc(1'h0, 8'h30, 8'h00, RESP_SLVERR);
    chk(rdv, 32'h0);
    rd(OFF_INT_CAUSE, 8'h00);
    acc(1'h1, OFF_INT_CAUSE, 8'hFF, RESP_OKAY);
    acc(1'h1, OFF_INT_ENABLE, 8'hFF, RESP_OKAY);
    rd(OFF_INT_ENABLE, INT_USED_MASK);
    rd(OFF_INT_CAUSE, 8'h00);
  endtask
  task automatic s_ep0();
    host.link(1'h0, 4'h1);
    nw(4);
    chk(32'(txArmed[0] & irqOutN), 32'h1);
    host.link(1'h1, 4'h1);
    nw(3);
    chk(32'(txArmed[0] | irqOutN), 32'h0);
    rd(OFF_INT_CAUSE, 8'h10);
    acc(1'h1, OFF_INT_ENABLE, 8'h86, RESP_OKAY);
    nw(2);
    chk(32'(irqOutN), 32'h1);
    acc(1'h1, OFF_INT_ENABLE, 8'h96, RESP_OKAY);
    arm(0, 8'h10, 7'h03, EP0_MAX_PKT);
  endtask
  task automatic s_rx();
    host.rx(0, 7'h05);
    nw(3);
    chk(32'(irqOutN), 32'h0);
    rd(OFF_INT_CAUSE, 8'h02);
    rd(OFF_EP1_RX_COUNT, 8'h05);
    rd(OFF_PACKET_READY, 8'h92);
    acc(1'h1, OFF_PACKET_READY, 8'h02, RESP_OKAY);
    nw(1);
    chk(32'(irqOutN), 32'h1);
    rd(OFF_PACKET_READY, 8'h90);
    host.rx(1, 7'h40);
    nw(3);
    rd(OFF_INT_CAUSE, 8'h04);
    rd(OFF_EP2_RX_COUNT, 8'h40);
    acc(1'h1, OFF_EP2_CONTROL, 8'h80, RESP_OKAY);
    nw(2);
    chk(32'(irqOutN), 32'h1);
    host.link(1'h1, 4'h5);
    nw(4);
    rd(OFF_INT_CAUSE, 8'h04);
    arm(2, 8'h40, 7'h20, EP2_MAX_PKT);
  endtask
  task automatic s_ep3();
    host.link(1'h1, 4'hF);
    nw(4);
    chk(32'(txArmed[3]), 32'h0);
    rd(OFF_INT_CAUSE, 8'h80);
    arm(3, 8'h80, 7'h07, EP3_MAX_PKT);
    // Endpoint 1 turned to transmit: its reset-time ready flag clears once the FIFO is free
    acc(1'h1, OFF_EP1_CONTROL, 8'h80, RESP_OKAY);
    rd(OFF_EP1_CONTROL, 8'h80);
    nw(2);
    chk(32'(irqOutN), 32'h0);
    rd(OFF_INT_CAUSE, 8'h02);
    arm(1, 8'h20, 7'h10, EP1_MAX_PKT);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'h1;
    s_reset();
    s_ep0();
    s_rx();
    s_ep3();
    stop_test();
  end
endmodule // test_usb_packet_ready_irq

// [dv/usb_host_model.sv]
`timescale 1ns/1ns
module usb_host_model (
  input wire logic clk,
  output logic ctrlReadDataStage,
  output logic [3:0] txFifoFree,
  output logic [3:0] txHostAck,
  output logic [6:0] txFillCount0,
  output logic [6:0] txFillCount1,
  output logic [6:0] txFillCount2,
  output logic [6:0] txFillCount3,
  output logic [1:0] rxPacketGood,
  output logic [6:0] rxByteCount
);
  logic [6:0] fill [4];
  assign txFillCount0 = fill[0];
  assign txFillCount1 = fill[1];
  assign txFillCount2 = fill[2];
  assign txFillCount3 = fill[3];
  initial begin
    ctrlReadDataStage = 1'h0;
    txFifoFree = 4'h0;
    txHostAck = 4'h0;
    rxPacketGood = 2'h0;
    rxByteCount = 7'h2A;
    fill = '{default: 7'h00};
  end
  task automatic ack(input int e);
    @(posedge clk);
    txHostAck[e] <= 1'h1;
    @(posedge clk);
    txHostAck[e] <= 1'h0;
  endtask
  task automatic rx(input int e, input logic [6:0] n);
    @(posedge clk);
    rxPacketGood[e] <= 1'h1;
    rxByteCount <= n;
    @(posedge clk);
    rxPacketGood[e] <= 1'h0;
    // Count is only valid with the pulse
    rxByteCount <= ~n;
  endtask
  task automatic link(input logic s, input logic [3:0] f);
    @(posedge clk);
    ctrlReadDataStage <= s;
    txFifoFree <= f;
  endtask
  task automatic load(input int e, input logic [6:0] n);
    @(posedge clk);
    fill[e] <= n;
  endtask
endmodule // usb_host_model

// [dv/usb_packet_ready_irq_chk.sv]
`timescale 1ns/1ns
module usb_packet_ready_irq_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire logic s_axi_bvalid,
  input wire logic ctrlReadDataStage,
  input wire logic [3:0] txFifoFree,
  input wire logic [3:0] txArmed,
  input wire logic [3:0] txShort,
  input wire logic [6:0] txSendLen0,
  input wire logic [6:0] txSendLen3,
  input wire logic [7:0] endpointStatus,
  input wire logic irqOutN
);
  import usb_pkt_irq_pkg::*;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);
  logic [3:0] hold;
  logic wrSeen_q;
  assign hold = txArmed & endpointStatus[3:0];
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) wrSeen_q <= 1'h0;
    else if (s_axi_bvalid) wrSeen_q <= 1'h1;
  end
  AST_EP0_HOLD: assert property (txArmed[0] && !ctrlReadDataStage |=> txArmed[0])
    else $error("ep0 ready cleared outside data stage");
  AST_EP0_CLR: assert property (txArmed[0] && !endpointStatus[0] && ctrlReadDataStage && txFifoFree[0]
    |=> !txArmed[0] || endpointStatus[0]) else $error("ep0 ready not cleared");
  AST_EP3_CLR: assert property (txArmed[3] && !endpointStatus[3] && txFifoFree[3]
    |=> !txArmed[3] || endpointStatus[3]) else $error("ep3 ready not cleared");
  AST_ACK_HOLD: assert property (hold != 4'h0 |=> &(txArmed | ~$past(hold)))
    else $error("ready cleared before host ack");
  AST_SHORT0: assert property (txShort[0] == (txArmed[0] && txSendLen0 < EP0_MAX_PKT))
    else $error("ep0 short flag wrong");
  AST_SHORT3: assert property (txShort[3] == (txArmed[3] && txSendLen3 < EP3_MAX_PKT))
    else $error("ep3 short flag wrong");
  AST_ARM_WR: assert property ((txArmed & ~$past(txArmed)) != 4'h0 |-> $rose(s_axi_bvalid))
    else $error("ready set without write");
  AST_AWAIT_ARM: assert property ($rose(endpointStatus[0]) |-> txArmed[0] && $rose(s_axi_bvalid))
    else $error("ack wait set without arming");
  AST_IRQ_MASK: assert property (!wrSeen_q |-> irqOutN)
    else $error("interrupt while all causes masked");
  cover property ($fell(irqOutN));
  cover property ($rose(txArmed[0]) && txShort[0]);
  cover property ($fell(txArmed[3]));
endmodule // usb_packet_ready_irq_chk
bind usb_packet_ready_irq usb_packet_ready_irq_chk chk (.*);

// [hw/rx_ready_flag.sv]
`timescale 1ns/1ns
module rx_ready_flag
  import usb_pkt_irq_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic packetGood,
  input wire logic [CNT_W-1:0] rxCount,
  input wire logic clearWrite,
  output logic flag,
  output logic [CNT_W-1:0] byteCount
);
  typedef struct packed {
    logic flag;
    logic [CNT_W-1:0] byteCount;
  } state_s;

  state_s s_q;
  state_s s_d;

  always_comb begin
    s_d = s_q;
    if (clearWrite) begin
      s_d.flag = 1'b0;
    end
    // A packet landing in the clearing cycle is kept
    if (packetGood) begin
      s_d.flag = 1'b1;
      s_d.byteCount = rxCount;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign flag = s_q.flag;
  assign byteCount = s_q.byteCount;

endmodule // rx_ready_flag

// [hw/tx_ready_flag.sv]
`timescale 1ns/1ns
module tx_ready_flag
  import usb_pkt_irq_pkg::*;
#(
  parameter logic [CNT_W-1:0] MAX_PKT = EP0_MAX_PKT
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic allowClear,
  input wire logic fifoFree,
  input wire logic hostAck,
  input wire logic armWrite,
  input wire logic [CNT_W-1:0] fillCount,
  output logic flag,
  output logic awaitAck,
  output logic [CNT_W-1:0] sendLen,
  output logic shortPacket
);
  typedef struct packed {
    logic flag;
    logic awaitAck;
    logic [CNT_W-1:0] sendLen;
  } state_s;

  state_s s_q;
  state_s s_d;

  always_comb begin
    s_d = s_q;
    if (hostAck) begin
      s_d.awaitAck = 1'b0;
    end
    if (s_q.flag && allowClear && fifoFree && !s_q.awaitAck) begin
      s_d.flag = 1'b0;
    end
    // Arming wins over a clear or an ACK in the same cycle
    if (armWrite) begin
      s_d.flag = 1'b1;
      s_d.awaitAck = 1'b1;
      s_d.sendLen = fillCount;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
      s_q.flag <= RST_TX_FLAG;
    end else begin
      s_q <= s_d;
    end
  end

  assign flag = s_q.flag;
  assign awaitAck = s_q.awaitAck;
  assign sendLen = s_q.sendLen;
  assign shortPacket = s_q.flag && (s_q.sendLen < MAX_PKT);

endmodule // tx_ready_flag

// [hw/usb_packet_ready_irq.sv]
// Implementation choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
module usb_packet_ready_irq
  import usb_pkt_irq_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [usb_pkt_irq_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [usb_pkt_irq_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ctrlReadDataStage,
  input wire logic [usb_pkt_irq_pkg::TX_EPS-1:0] txFifoFree,
  input wire logic [usb_pkt_irq_pkg::TX_EPS-1:0] txHostAck,
  input wire logic [usb_pkt_irq_pkg::CNT_W-1:0] txFillCount0,
  input wire logic [usb_pkt_irq_pkg::CNT_W-1:0] txFillCount1,
  input wire logic [usb_pkt_irq_pkg::CNT_W-1:0] txFillCount2,
  input wire logic [usb_pkt_irq_pkg::CNT_W-1:0] txFillCount3,
  input wire logic [usb_pkt_irq_pkg::RX_EPS-1:0] rxPacketGood,
  input wire logic [usb_pkt_irq_pkg::CNT_W-1:0] rxByteCount,
  output logic [usb_pkt_irq_pkg::TX_EPS-1:0] txArmed,
  output logic [usb_pkt_irq_pkg::TX_EPS-1:0] txShort,
  output logic [usb_pkt_irq_pkg::CNT_W-1:0] txSendLen0,
  output logic [usb_pkt_irq_pkg::CNT_W-1:0] txSendLen1,
  output logic [usb_pkt_irq_pkg::CNT_W-1:0] txSendLen2,
  output logic [usb_pkt_irq_pkg::CNT_W-1:0] txSendLen3,
  output logic [7:0] endpointStatus,
  output logic irqOutN
);
  import usb_pkt_irq_pkg::*;

  typedef struct packed {
    logic awSeen;
    logic wSeen;
    logic [ADDR_W-1:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic [7:0] intEnable;
    logic ep1Dir;
    logic ep2Dir;
    logic irqN;
  } state_s;

  state_s s_q;
  state_s s_d;

  // Per-endpoint flag wiring: tx index 0..3 is EP0..EP3, rx index 0..1 is EP1..EP2
  logic [TX_EPS-1:0] txFlag;
  logic [TX_EPS-1:0] txAwait;
  logic [TX_EPS-1:0] txAllow;
  logic [TX_EPS-1:0] txArmWrite;
  logic [CNT_W-1:0] txLen [TX_EPS];
  logic [CNT_W-1:0] txFill [TX_EPS];
  logic [RX_EPS-1:0] rxFlag;
  logic [RX_EPS-1:0] rxGood;
  logic [RX_EPS-1:0] rxClearWrite;
  logic [CNT_W-1:0] rxCount [RX_EPS];
  logic [7:0] pktFlags;
  logic [7:0] causeFlags;
  logic wrCommit;
  logic pktWrite;
  logic wrKnown;
  logic [31:0] rdValue;

  function automatic logic addrKnown(input logic [ADDR_W-1:0] a);
    case (a)
      OFF_PACKET_READY, OFF_INT_ENABLE, OFF_INT_CAUSE, OFF_EP1_CONTROL, OFF_EP2_CONTROL,
      OFF_EP1_RX_COUNT, OFF_EP2_RX_COUNT, OFF_ENDPOINT_STATUS,
      OFF_EP0_TX_LEN, OFF_EP1_TX_LEN, OFF_EP2_TX_LEN, OFF_EP3_TX_LEN: addrKnown = 1'b1;
      default: addrKnown = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] countWord(input logic [CNT_W-1:0] c);
    countWord = {{(32 - CNT_W){1'b0}}, c};
  endfunction

  assign txFill[0] = txFillCount0;
  assign txFill[1] = txFillCount1;
  assign txFill[2] = txFillCount2;
  assign txFill[3] = txFillCount3;

  // Hardware may clear a transmit flag only where the endpoint is really transmitting
  assign txAllow[0] = ctrlReadDataStage;
  assign txAllow[1] = s_q.ep1Dir;
  assign txAllow[2] = s_q.ep2Dir;
  assign txAllow[3] = 1'b1;

  // Received packets count only on endpoints set to receive
  assign rxGood[0] = rxPacketGood[0] && !s_q.ep1Dir;
  assign rxGood[1] = rxPacketGood[1] && !s_q.ep2Dir;

  // Register writes take effect in the cycle the response is raised
  assign wrCommit = s_q.awSeen && s_q.wSeen && !s_q.bValid;
  assign wrKnown = addrKnown(s_q.awAddr);
  assign pktWrite = wrCommit && (s_q.awAddr == OFF_PACKET_READY) && s_q.wStrb[0];

  assign txArmWrite[0] = pktWrite && s_q.wData[BIT_EP0_TX_RDY];
  assign txArmWrite[1] = pktWrite && s_q.wData[BIT_EP1_TX_RDY] && s_q.ep1Dir;
  assign txArmWrite[2] = pktWrite && s_q.wData[BIT_EP2_TX_RDY] && s_q.ep2Dir;
  assign txArmWrite[3] = pktWrite && s_q.wData[BIT_EP3_TX_RDY];
  assign rxClearWrite[0] = pktWrite && s_q.wData[BIT_EP1_RX_RDY] && !s_q.ep1Dir;
  assign rxClearWrite[1] = pktWrite && s_q.wData[BIT_EP2_RX_RDY] && !s_q.ep2Dir;

  genvar gi;
  generate
    for (gi = 0; gi < TX_EPS; gi++) begin : gTx
      localparam logic [CNT_W-1:0] MAXP = (gi == 0) ? EP0_MAX_PKT :
                                          (gi == 1) ? EP1_MAX_PKT :
                                          (gi == 2) ? EP2_MAX_PKT : EP3_MAX_PKT;
      tx_ready_flag #(
        .MAX_PKT(MAXP)
      ) uTx (
        .clk(clk),
        .resetn(resetn),
        .allowClear(txAllow[gi]),
        .fifoFree(txFifoFree[gi]),
        .hostAck(txHostAck[gi]),
        .armWrite(txArmWrite[gi]),
        .fillCount(txFill[gi]),
        .flag(txFlag[gi]),
        .awaitAck(txAwait[gi]),
        .sendLen(txLen[gi]),
        .shortPacket(txShort[gi])
      );
    end
    for (gi = 0; gi < RX_EPS; gi++) begin : gRx
      rx_ready_flag uRx (
        .clk(clk),
        .resetn(resetn),
        .packetGood(rxGood[gi]),
        .rxCount(rxByteCount),
        .clearWrite(rxClearWrite[gi]),
        .flag(rxFlag[gi]),
        .byteCount(rxCount[gi])
      );
    end
  endgenerate

  always_comb begin
    pktFlags = 8'h00;
    pktFlags[BIT_EP1_RX_RDY] = rxFlag[0] && !s_q.ep1Dir;
    pktFlags[BIT_EP2_RX_RDY] = rxFlag[1] && !s_q.ep2Dir;
    pktFlags[BIT_EP0_TX_RDY] = txFlag[0];
    pktFlags[BIT_EP1_TX_RDY] = txFlag[1] && s_q.ep1Dir;
    pktFlags[BIT_EP2_TX_RDY] = txFlag[2] && s_q.ep2Dir;
    pktFlags[BIT_EP3_TX_RDY] = txFlag[3];
  end

  always_comb begin
    causeFlags = 8'h00;
    causeFlags[BIT_INT_EP0_TX] = s_q.intEnable[BIT_INT_EP0_TX] && !txFlag[0];
    causeFlags[BIT_INT_EP1] = s_q.intEnable[BIT_INT_EP1] &&
                              (s_q.ep1Dir ? !txFlag[1] : rxFlag[0]);
    causeFlags[BIT_INT_EP2] = s_q.intEnable[BIT_INT_EP2] &&
                              (s_q.ep2Dir ? !txFlag[2] : rxFlag[1]);
    causeFlags[BIT_INT_EP3] = s_q.intEnable[BIT_INT_EP3] && !txFlag[3];
  end

  always_comb begin
    rdValue = 32'h0000_0000;
    case (s_axi_araddr)
      OFF_PACKET_READY: rdValue = {24'h00_0000, pktFlags};
      OFF_INT_ENABLE: rdValue = {24'h00_0000, s_q.intEnable};
      OFF_INT_CAUSE: rdValue = {24'h00_0000, causeFlags};
      OFF_EP1_CONTROL: rdValue = {24'h00_0000, s_q.ep1Dir, 7'h00};
      OFF_EP2_CONTROL: rdValue = {24'h00_0000, s_q.ep2Dir, 7'h00};
      OFF_EP1_RX_COUNT: rdValue = countWord(rxCount[0]);
      OFF_EP2_RX_COUNT: rdValue = countWord(rxCount[1]);
      OFF_ENDPOINT_STATUS: rdValue = {24'h00_0000, txShort, txAwait};
      OFF_EP0_TX_LEN: rdValue = countWord(txLen[0]);
      OFF_EP1_TX_LEN: rdValue = countWord(txLen[1]);
      OFF_EP2_TX_LEN: rdValue = countWord(txLen[2]);
      OFF_EP3_TX_LEN: rdValue = countWord(txLen[3]);
      default: rdValue = 32'h0000_0000;
    endcase
  end

  always_comb begin
    s_d = s_q;
    // Write address and data are taken independently, in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.awSeen = 1'b1;
      s_d.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.wSeen = 1'b1;
      s_d.wData = s_axi_wdata;
      s_d.wStrb = s_axi_wstrb;
    end
    if (wrCommit) begin
      s_d.awSeen = 1'b0;
      s_d.wSeen = 1'b0;
      s_d.bValid = 1'b1;
      s_d.bResp = wrKnown ? RESP_OKAY : RESP_SLVERR;
      if (s_q.wStrb[0]) begin
        case (s_q.awAddr)
          OFF_INT_ENABLE: s_d.intEnable = s_q.wData[7:0] & INT_USED_MASK;
          OFF_EP1_CONTROL: s_d.ep1Dir = s_q.wData[BIT_DIR];
          OFF_EP2_CONTROL: s_d.ep2Dir = s_q.wData[BIT_DIR];
          default: s_d.intEnable = s_q.intEnable;
        endcase
      end
    end
    if (s_q.bValid && s_axi_bready) begin
      s_d.bValid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      s_d.rValid = 1'b1;
      s_d.rData = rdValue;
      s_d.rResp = addrKnown(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_q.rValid && s_axi_rready) begin
      s_d.rValid = 1'b0;
    end
    s_d.irqN = !(|causeFlags);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
      s_q.intEnable <= RST_INT_ENABLE;
      s_q.ep1Dir <= RST_DIR;
      s_q.ep2Dir <= RST_DIR;
      s_q.irqN <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = !s_q.awSeen && !s_q.bValid;
  assign s_axi_wready = !s_q.wSeen && !s_q.bValid;
  assign s_axi_bvalid = s_q.bValid;
  assign s_axi_bresp = s_q.bResp;
  assign s_axi_arready = !s_q.rValid;
  assign s_axi_rvalid = s_q.rValid;
  assign s_axi_rdata = s_q.rData;
  assign s_axi_rresp = s_q.rResp;

  assign txArmed = txFlag;
  assign txSendLen0 = txLen[0];
  assign txSendLen1 = txLen[1];
  assign txSendLen2 = txLen[2];
  assign txSendLen3 = txLen[3];
  assign endpointStatus = {txShort, txAwait};
  assign irqOutN = s_q.irqN;

endmodule // usb_packet_ready_irq

// [hw/usb_pkt_irq_pkg.sv]
package usb_pkt_irq_pkg;

  // Register byte offsets
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_PACKET_READY = 8'h00;
  localparam logic [7:0] OFF_INT_ENABLE = 8'h04;
  localparam logic [7:0] OFF_INT_CAUSE = 8'h08;
  localparam logic [7:0] OFF_EP1_CONTROL = 8'h0C;
  localparam logic [7:0] OFF_EP2_CONTROL = 8'h10;
  localparam logic [7:0] OFF_EP1_RX_COUNT = 8'h14;
  localparam logic [7:0] OFF_EP2_RX_COUNT = 8'h18;
  localparam logic [7:0] OFF_ENDPOINT_STATUS = 8'h1C;
  localparam logic [7:0] OFF_EP0_TX_LEN = 8'h20;
  localparam logic [7:0] OFF_EP1_TX_LEN = 8'h24;
  localparam logic [7:0] OFF_EP2_TX_LEN = 8'h28;
  localparam logic [7:0] OFF_EP3_TX_LEN = 8'h2C;

  // Bit positions in packet_ready_flags
  localparam int BIT_EP1_RX_RDY = 1;
  localparam int BIT_EP2_RX_RDY = 2;
  localparam int BIT_EP0_TX_RDY = 4;
  localparam int BIT_EP1_TX_RDY = 5;
  localparam int BIT_EP2_TX_RDY = 6;
  localparam int BIT_EP3_TX_RDY = 7;

  // Bit positions in interrupt_enable_mask and interrupt_cause_flags
  localparam int BIT_INT_EP1 = 1;
  localparam int BIT_INT_EP2 = 2;
  localparam int BIT_INT_EP0_TX = 4;
  localparam int BIT_INT_EP3 = 7;
  localparam logic [7:0] INT_USED_MASK = 8'h96;

  // Direction bit in endpoint_control: 1 transmit, 0 receive
  localparam int BIT_DIR = 7;

  // Reset values
  localparam logic [7:0] RST_INT_ENABLE = 8'h00;
  localparam logic RST_DIR = 1'b0;
  localparam logic RST_TX_FLAG = 1'b1;

  // Packet sizes
  localparam int CNT_W = 7;
  localparam int TX_EPS = 4;
  localparam int RX_EPS = 2;
  localparam logic [CNT_W-1:0] EP0_MAX_PKT = 7'h08;
  localparam logic [CNT_W-1:0] EP1_MAX_PKT = 7'h40;
  localparam logic [CNT_W-1:0] EP2_MAX_PKT = 7'h40;
  localparam logic [CNT_W-1:0] EP3_MAX_PKT = 7'h08;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage
